// file: common/tks_defs.svh
// Constants for the touch-key I2C slave port: locations, addresses, timing counts.
`ifndef TKS_DEFS_SVH
`define TKS_DEFS_SVH

`define TKS_LOC_RSVD 8'h00
`define TKS_LOC_DET_LO 8'h01
`define TKS_LOC_DET_MID 8'h02
`define TKS_LOC_DET_HI 8'h03
`define TKS_LOC_RAW_FIRST 8'h04
`define TKS_LOC_RAW_LAST 8'h7B
`define TKS_LOC_RECAL 8'h7D
`define TKS_LOC_UNLOCK 8'h82
`define TKS_LOC_SETUP_FIRST 8'h83
`define TKS_LOC_SETUP_LAST 8'hFD
`define TKS_LOC_PTR_MAX 8'hFF
`define TKS_LOC_WAKE_0 8'hF0
`define TKS_LOC_WAKE_1 8'hF1
`define TKS_LOC_WAKE_2 8'hF2
`define TKS_MAGIC 8'h55
`define TKS_SLA_7 7'h07
`define TKS_SLA_17 7'h11
`define TKS_SLA_117 7'h75
`define TKS_SLA_NONE 7'h00
`define TKS_SETUP_DEPTH 123
`define TKS_SETUP_RESET 8'h00
`define TKS_WAKE_RESET 8'hFF
`define TKS_LOAD_CYCLES 2'h2
`define TKS_BITS_PER_BYTE 4'h8

`endif

// file: common/tks_pkg.sv
// Types shared by the touch-key I2C slave port.
package tks_pkg;

  typedef enum logic [2:0] {
    TKS_IDLE     = 3'b000,
    TKS_DEV_ADDR = 3'b001,
    TKS_LOC      = 3'b010,
    TKS_WDATA    = 3'b011,
    TKS_ACK      = 3'b100,
    TKS_LOAD     = 3'b101,
    TKS_RDATA    = 3'b110,
    TKS_HOST_ACK = 3'b111
  } tks_state_e;

  typedef struct packed {
    logic scl_i;
    logic sda_i;
  } tks_bus_in_s;

  typedef struct packed {
    logic scl_o;
    logic scl_oe_n;
    logic sda_o;
    logic sda_oe_n;
  } tks_bus_out_s;

endpackage

// file: design/tks_i2c_slave.sv
// I2C slave port of the touch-key sensor with its byte-addressed location map.
//
// Operation
// - Slave only, 7-bit address; transactions to other addresses are ignored.
// - Select pins: 00 off, 01 address 7, 10 address 17, 11 address 117.
// - Each byte read advances the internal pointer.
// - Change alert rises only when a key is touched or released.
// - Change alert stays high until a read of location 1 clears it.
// - Only keys with their wake bit set raise the change alert.
// - Locations 1 to 3 give detect bits for keys 0-23; location 0 reserved.
// - Locations 4 to 123 give per-key raw data in key order.
// - Writing 0x55 to location 125 recalibrates every key.
// - Writing 0x55 to location 130 unlocks setup writes.
// - Any read locks the setups again until a new unlock.
// - Locations 131 to 253 hold the readable and writable setups block.
// - Write: address, location and every data byte are acknowledged.
// - Multi-byte writes store each byte then advance the location.
// - The location pointer never advances past 255.
// - Read: bytes follow each host ACK until the host answers NACK.
// - The device may hold SCL low between bytes for processing time.
`timescale 1ns/1ps
`include "tks_defs.svh"

module tks_i2c_slave
  import tks_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // I2C bus pins.
  input wire tks_bus_in_s bus_in,
  output tks_bus_out_s bus_out,
  // Address select straps.
  input wire logic addr_select_hi,
  input wire logic addr_select_lo,
  // Sensor core side.
  input wire logic [23:0] key_detect,
  output logic [6:0] raw_index,
  input wire logic [7:0] raw_byte,
  output logic recal_all,
  // Host alert.
  output logic change_alert
);

  tks_state_e state_reg;
  tks_state_e after_reg;
  logic scl_q_reg, sda_q_reg, scl_p_reg, sda_p_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] ptr_reg;
  logic [1:0] stretch_reg;
  logic sda_oe_n_reg;
  logic host_ack_reg;
  logic unlock_reg;
  logic [23:0] det_prev_reg;
  logic [7:0] setup_mem [0:`TKS_SETUP_DEPTH-1];

  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic byte_done, port_on, read_load, wr_fire;
  logic [6:0] own_addr;
  logic [7:0] ptr_next, read_byte;
  logic [6:0] setup_idx;
  logic [23:0] wake_mask, key_changed;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      scl_p_reg <= 1'b1;
      sda_p_reg <= 1'b1;
    end else begin
      scl_q_reg <= bus_in.scl_i;
      sda_q_reg <= bus_in.sda_i;
      scl_p_reg <= scl_q_reg;
      sda_p_reg <= sda_q_reg;
    end
  end

  assign scl_rise = scl_q_reg & ~scl_p_reg;
  assign scl_fall = ~scl_q_reg & scl_p_reg;
  assign bus_start = scl_q_reg & scl_p_reg & sda_p_reg & ~sda_q_reg;
  assign bus_stop = scl_q_reg & scl_p_reg & ~sda_p_reg & sda_q_reg;
  assign byte_done = (bit_cnt_reg == `TKS_BITS_PER_BYTE);

  // Straps pick the slave address or switch the port off.
  always_comb begin
    case ({addr_select_hi, addr_select_lo})
      2'b01: own_addr = `TKS_SLA_7;
      2'b10: own_addr = `TKS_SLA_17;
      2'b11: own_addr = `TKS_SLA_117;
      default: own_addr = `TKS_SLA_NONE;
    endcase
  end
  assign port_on = addr_select_hi | addr_select_lo;

  // Pointer holds at the top location.
  assign ptr_next = (ptr_reg == `TKS_LOC_PTR_MAX) ? ptr_reg : ptr_reg + 8'h01;
  assign setup_idx = 7'(ptr_reg - `TKS_LOC_SETUP_FIRST);
  assign read_load = (state_reg == TKS_LOAD) && (stretch_reg == 2'h1);
  assign wr_fire = (state_reg == TKS_WDATA) && scl_fall && byte_done;

  // Read map of the locations.
  always_comb begin
    if (ptr_reg == `TKS_LOC_DET_LO) begin
      read_byte = key_detect[7:0];
    end else if (ptr_reg == `TKS_LOC_DET_MID) begin
      read_byte = key_detect[15:8];
    end else if (ptr_reg == `TKS_LOC_DET_HI) begin
      read_byte = key_detect[23:16];
    end else if (ptr_reg >= `TKS_LOC_RAW_FIRST && ptr_reg <= `TKS_LOC_RAW_LAST) begin
      read_byte = raw_byte;
    end else if (ptr_reg >= `TKS_LOC_SETUP_FIRST && ptr_reg <= `TKS_LOC_SETUP_LAST) begin
      read_byte = setup_mem[setup_idx];
    end else begin
      read_byte = 8'h00;
    end
  end

  // Bus protocol engine.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= TKS_IDLE;
      after_reg <= TKS_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      stretch_reg <= 2'h0;
      sda_oe_n_reg <= 1'b1;
      host_ack_reg <= 1'b0;
      raw_index <= 7'h00;
    end else if (bus_start) begin
      state_reg <= port_on ? TKS_DEV_ADDR : TKS_IDLE;
      bit_cnt_reg <= 4'h0;
      sda_oe_n_reg <= 1'b1;
    end else if (bus_stop) begin
      state_reg <= TKS_IDLE;
      sda_oe_n_reg <= 1'b1;
    end else begin
      case (state_reg)
        TKS_DEV_ADDR, TKS_LOC, TKS_WDATA: begin
          if (scl_rise && !byte_done) begin
            shift_reg <= {shift_reg[6:0], sda_q_reg};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && byte_done) begin
            bit_cnt_reg <= 4'h0;
            sda_oe_n_reg <= 1'b0;
            state_reg <= TKS_ACK;
            if (state_reg == TKS_DEV_ADDR) begin
              if (shift_reg[7:1] != own_addr) begin
                sda_oe_n_reg <= 1'b1;
                state_reg <= TKS_IDLE;
              end
              after_reg <= shift_reg[0] ? TKS_RDATA : TKS_LOC;
            end else if (state_reg == TKS_LOC) begin
              ptr_reg <= shift_reg;
              after_reg <= TKS_WDATA;
            end else begin
              ptr_reg <= ptr_next;
              after_reg <= TKS_WDATA;
            end
          end
        end
        TKS_ACK: begin
          if (scl_fall) begin
            sda_oe_n_reg <= 1'b1;
            if (after_reg == TKS_RDATA) begin
              state_reg <= TKS_LOAD;
              stretch_reg <= `TKS_LOAD_CYCLES;
              raw_index <= 7'(ptr_reg - `TKS_LOC_RAW_FIRST);
            end else begin
              state_reg <= after_reg;
            end
          end
        end
        TKS_LOAD: begin
          stretch_reg <= stretch_reg - 2'h1;
          if (stretch_reg == 2'h1) begin
            shift_reg <= read_byte;
            sda_oe_n_reg <= read_byte[7];
            bit_cnt_reg <= 4'h1;
            ptr_reg <= ptr_next;
            state_reg <= TKS_RDATA;
          end
        end
        TKS_RDATA: begin
          if (scl_fall) begin
            if (byte_done) begin
              sda_oe_n_reg <= 1'b1;
              state_reg <= TKS_HOST_ACK;
            end else begin
              sda_oe_n_reg <= shift_reg[6];
              shift_reg <= {shift_reg[6:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        TKS_HOST_ACK: begin
          if (scl_rise) begin
            host_ack_reg <= ~sda_q_reg;
          end else if (scl_fall) begin
            if (host_ack_reg) begin
              state_reg <= TKS_LOAD;
              stretch_reg <= `TKS_LOAD_CYCLES;
              raw_index <= 7'(ptr_reg - `TKS_LOC_RAW_FIRST);
            end else begin
              state_reg <= TKS_IDLE;
            end
          end
        end
        default: begin
          state_reg <= TKS_IDLE;
        end
      endcase
    end
  end

  assign bus_out.scl_o = 1'b0;
  assign bus_out.scl_oe_n = (state_reg != TKS_LOAD);
  assign bus_out.sda_o = 1'b0;
  assign bus_out.sda_oe_n = sda_oe_n_reg;

  // Setup write protection.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unlock_reg <= 1'b0;
    end else if (read_load) begin
      unlock_reg <= 1'b0;
    end else if (wr_fire && ptr_reg == `TKS_LOC_UNLOCK && shift_reg == `TKS_MAGIC) begin
      unlock_reg <= 1'b1;
    end
  end

  // Setups store; other writes are acknowledged but dropped.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `TKS_SETUP_DEPTH; i++) begin
        setup_mem[i] <= `TKS_SETUP_RESET;
      end
      setup_mem[7'(`TKS_LOC_WAKE_0 - `TKS_LOC_SETUP_FIRST)] <= `TKS_WAKE_RESET;
      setup_mem[7'(`TKS_LOC_WAKE_1 - `TKS_LOC_SETUP_FIRST)] <= `TKS_WAKE_RESET;
      setup_mem[7'(`TKS_LOC_WAKE_2 - `TKS_LOC_SETUP_FIRST)] <= `TKS_WAKE_RESET;
    end else if (wr_fire && unlock_reg && ptr_reg >= `TKS_LOC_SETUP_FIRST &&
                 ptr_reg <= `TKS_LOC_SETUP_LAST) begin
      setup_mem[setup_idx] <= shift_reg;
    end
  end

  // Recalibrate command pulse.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      recal_all <= 1'b0;
    end else begin
      recal_all <= wr_fire && ptr_reg == `TKS_LOC_RECAL && shift_reg == `TKS_MAGIC;
    end
  end

  // Change alert: set wins over the clear by a read of location 1.
  assign wake_mask = {setup_mem[7'(`TKS_LOC_WAKE_2 - `TKS_LOC_SETUP_FIRST)],
                      setup_mem[7'(`TKS_LOC_WAKE_1 - `TKS_LOC_SETUP_FIRST)],
                      setup_mem[7'(`TKS_LOC_WAKE_0 - `TKS_LOC_SETUP_FIRST)]};
  assign key_changed = (key_detect ^ det_prev_reg) & wake_mask;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      det_prev_reg <= 24'h000000;
      change_alert <= 1'b0;
    end else begin
      det_prev_reg <= key_detect;
      if (|key_changed) begin
        change_alert <= 1'b1;
      end else if (read_load && ptr_reg == `TKS_LOC_DET_LO) begin
        change_alert <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence seq_load_entry;
    $rose(state_reg == TKS_LOAD);
  endsequence

  sequence seq_scl_held;
    !bus_out.scl_oe_n [*2] ##1 bus_out.scl_oe_n;
  endsequence

  chk_scl_stretch_len: assert property (seq_load_entry |-> seq_scl_held)
    else $error("SCL hold does not last the load time");

  chk_alert_hold: assert property (
    change_alert && !(read_load && ptr_reg == `TKS_LOC_DET_LO) |=> change_alert)
    else $error("Change alert dropped without a read of location 1");

  chk_alert_cause: assert property ($rose(change_alert) |-> $past(|key_changed))
    else $error("Change alert rose without an enabled key change");

  chk_alert_clear: assert property (
    read_load && ptr_reg == `TKS_LOC_DET_LO && !(|key_changed) |=> !change_alert)
    else $error("Read of location 1 did not clear the change alert");

  chk_ptr_read_step: assert property (
    read_load && ptr_reg != `TKS_LOC_PTR_MAX |=> ptr_reg == 8'($past(ptr_reg) + 8'h01))
    else $error("Pointer did not advance after a byte read");

  chk_ptr_top_hold: assert property (
    ptr_reg == `TKS_LOC_PTR_MAX && (read_load || wr_fire) |=> ptr_reg == `TKS_LOC_PTR_MAX)
    else $error("Pointer advanced past the top location");

  chk_recal_cmd: assert property (
    wr_fire && ptr_reg == `TKS_LOC_RECAL && shift_reg == `TKS_MAGIC |=> recal_all ##1 !recal_all)
    else $error("Recalibrate pulse missing or too long");

  chk_read_locks: assert property (read_load |=> !unlock_reg)
    else $error("Setups stay unlocked after a read");

  chk_addr_miss: assert property (
    state_reg == TKS_DEV_ADDR && scl_fall && byte_done && !bus_start && !bus_stop &&
    shift_reg[7:1] != own_addr |=> state_reg == TKS_IDLE && sda_oe_n_reg)
    else $error("Device answered a foreign address");

  chk_data_ack: assert property (
    wr_fire && !bus_start && !bus_stop |=> (state_reg == TKS_ACK && !sda_oe_n_reg) [*2])
    else $error("Data byte was not acknowledged");

  chk_locked_drop: assert property (
    wr_fire && !unlock_reg && ptr_reg >= `TKS_LOC_SETUP_FIRST &&
    ptr_reg <= `TKS_LOC_SETUP_LAST |=> setup_mem[$past(setup_idx)] == $past(read_byte))
    else $error("Locked setup location was overwritten");

  chk_ptr_write_step: assert property (
    wr_fire && ptr_reg != `TKS_LOC_PTR_MAX && !bus_start && !bus_stop |=>
    ptr_reg == 8'($past(ptr_reg) + 8'h01))
    else $error("Pointer did not advance after a byte write");

  chk_port_off: assert property (
    !port_on && state_reg == TKS_IDLE |=> state_reg == TKS_IDLE)
    else $error("Port left idle while the straps switch it off");

endmodule

// file: bench/tks_host_model.sv
// Host microcontroller model: I2C bus master driving SCL and SDA through open drains.
`timescale 1ns/1ps
module tks_host_model (
  // Clock.
  input wire logic clk,
  // Resolved bus lines.
  input wire logic scl_line,
  input wire logic sda_line,
  // Open-drain drives, where 1 releases the line.
  output logic scl_drv,
  output logic sda_drv,
  // Result of each byte: the acknowledge bit or the byte read.
  output logic res_valid,
  output logic [7:0] res_data
);
  localparam int Q = 125;

  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
    res_valid = 1'b0;
    res_data = 8'h00;
  end

  // A quarter bit of a 100 kHz bus clock.
  task automatic wq();
    repeat (Q) @(negedge clk);
  endtask

  // Called only on an idle bus, after reset or a STOP, so a repeated START never occurs.
  task automatic start();
    sda_drv = 1'b1;
    wq();
    sda_drv = 1'b0;
    wq();
    scl_drv = 1'b0;
    wq();
  endtask

  task automatic stop();
    sda_drv = 1'b0;
    wq();
    scl_drv = 1'b1;
    wq();
    sda_drv = 1'b1;
    wq();
    wq();
  endtask

  // One bit; the high phase waits until the device lets SCL go.
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    wq();
    scl_drv = 1'b1;
    for (int i = 0; i < 1000 && scl_line !== 1'b1; i++) @(negedge clk);
    wq();
    r = sda_line;
    wq();
    scl_drv = 1'b0;
    wq();
  endtask

  task automatic emit(input logic [7:0] v);
    res_data = v;
    res_valid = 1'b1;
    @(negedge clk);
    res_valid = 1'b0;
  endtask

  task automatic write_byte(input logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'b1, r);
    emit({7'h00, r});
  endtask

  // The last byte is answered with NACK, the others with ACK.
  task automatic read_byte(input logic last);
    logic [7:0] v;
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(last, r);
    emit(v);
  endtask
endmodule

// file: bench/touch_key_i2c_slave_port_tb.sv
// Self-checking testbench of the touch-key I2C slave port.
`timescale 1ns/1ps
module touch_key_i2c_slave_port_tb;
  import tks_pkg::*;
  typedef struct {
    string name;
    logic [7:0] val;
  } tks_exp_s;
  logic clk, rst_n, recal_all, change_alert, scl_drv, sda_drv, res_valid;
  logic [23:0] key_detect;
  logic [23:0] kd;
  logic [6:0] raw_index;
  logic [7:0] raw_byte;
  logic [7:0] res_data;
  logic [6:0] sla;
  logic [6:0] other;
  logic [1:0] strap;
  tks_bus_in_s bus_in;
  tks_bus_out_s bus_out;
  tks_exp_s exp_q[$];
  tks_exp_s e;
  int n_errors = 0;
  int n_compared = 0;
  int recal_cnt = 0;

  // Open-drain lines with pull-ups.
  assign bus_in = '{scl_i: scl_drv & (bus_out.scl_oe_n | bus_out.scl_o),
                    sda_i: sda_drv & (bus_out.sda_oe_n | bus_out.sda_o)};

  tks_i2c_slave i_tks_i2c_slave (.clk(clk), .rst_n(rst_n), .bus_in(bus_in), .bus_out(bus_out),
    .addr_select_hi(strap[1]), .addr_select_lo(strap[0]), .key_detect(key_detect),
    .raw_index(raw_index), .raw_byte(raw_byte), .recal_all(recal_all),
    .change_alert(change_alert));

  tks_host_model i_tks_host_model (.clk(clk), .scl_line(bus_in.scl_i),
    .sda_line(bus_in.sda_i), .scl_drv(scl_drv), .sda_drv(sda_drv), .res_valid(res_valid),
    .res_data(res_data));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(negedge clk) raw_byte <= {1'b1, raw_index};

  always @(negedge clk) begin
    if (recal_all === 1'b1) recal_cnt++;
  end

  // Each byte result seen on the bus is compared with the oldest expectation.
  always @(posedge clk) begin
    if (res_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("unexpected", res_data, 8'hXX);
      end else begin
        e = exp_q.pop_front();
        check(e.name, res_data, e.val);
      end
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic done(input string name);
    $display("Test %s done", name);
  endtask

  task automatic wr(input logic [7:0] b[$], input logic [7:0] ack0);
    i_tks_host_model.start();
    foreach (b[i]) begin
      exp_q.push_back('{"ack", (i == 0) ? ack0 : 8'h00});
      i_tks_host_model.write_byte(b[i]);
    end
    i_tks_host_model.stop();
  endtask

  // Sets the location, stops, then reads with a fresh START.
  task automatic rd(input logic [7:0] loc, input logic [7:0] v[$]);
    wr('{{sla, 1'b0}, loc}, 8'h00);
    i_tks_host_model.start();
    exp_q.push_back('{"ack", 8'h00});
    i_tks_host_model.write_byte({sla, 1'b1});
    foreach (v[i]) begin
      exp_q.push_back('{"rdata", v[i]});
      i_tks_host_model.read_byte(i == v.size() - 1);
    end
    i_tks_host_model.stop();
  endtask

  task automatic print_verdict();
    check("pending", 8'(exp_q.size()), 8'h00);
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (125000) @(posedge clk);
    n_errors++;
    print_verdict();
  end

  initial begin
    rst_n = 1'b0;
    key_detect = 24'h000000;
    raw_byte = 8'h00;
    void'($urandom(67));
    strap = 2'h1 + 2'($urandom_range(2));
    sla = (strap == 2'h1) ? 7'h07 : (strap == 2'h2) ? 7'h11 : 7'h75;
    other = (sla == 7'h07) ? 7'h11 : 7'h07;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    check("alert_reset", {7'h00, change_alert}, 8'h00);
    kd = 24'($urandom) | 24'h000001;
    key_detect = kd;
    repeat (2) @(negedge clk);
    check("alert_set", {7'h00, change_alert}, 8'h01);
    done("alert");
    wr('{{other, 1'b0}}, 8'h01);
    done("address");
    wr('{{sla, 1'b0}, 8'h7D, 8'h55}, 8'h00);
    check("recal", 8'(recal_cnt), 8'h01);
    done("recal");
    wr('{{sla, 1'b0}, 8'h82, 8'h55, 8'hA5}, 8'h00);
    check("alert_hold", {7'h00, change_alert}, 8'h01);
    done("unlock");
    rd(8'h01, '{kd[7:0], kd[15:8], kd[23:16], 8'h80});
    check("alert_clear", {7'h00, change_alert}, 8'h00);
    done("status");
    wr('{{sla, 1'b0}, 8'h83, 8'h00}, 8'h00);
    rd(8'h83, '{8'hA5});
    check("recal_once", 8'(recal_cnt), 8'h01);
    done("setups");
    strap = 2'h0;
    wr('{{sla, 1'b0}}, 8'h01);
    done("port_off");
    repeat (4) @(negedge clk);
    print_verdict();
  end
endmodule
